/* rtl/ctm_pkg.sv */
/*
  Shared constants and types for the timer-pair mode control block.
  Assumes a single clock domain and an AXI4-Lite master with 32-bit data.
*/
package ctm_pkg;

  // ----------------------------------------------------------------
  // bus layout
  // ----------------------------------------------------------------
  localparam int CTM_ADDR_W = 12;
  localparam logic [CTM_ADDR_W-1:0] CTM_MODE_CTRL_OFFSET = 12'h000;
  localparam logic [1:0] CTM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CTM_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // mode control register fields
  // ----------------------------------------------------------------
  localparam int CTM_UPPER_STATUS_BIT = 7;
  localparam int CTM_LOWER_STATUS_BIT = 6;
  localparam int CTM_INPUT_SRC_BIT = 5;
  localparam int CTM_WIDTH_SEL_BIT = 4;
  localparam int CTM_UPPER_FILT_LSB = 2;
  localparam int CTM_LOWER_FILT_LSB = 0;
  localparam logic [7:0] CTM_MODE_CTRL_RESET = 8'h00;

  // filter field encoding
  localparam logic [1:0] CTM_FILT_NONE = 2'h0;
  localparam logic [1:0] CTM_FILT_HIGH = 2'h1;
  localparam logic [1:0] CTM_FILT_LOW = 2'h2;
  localparam logic [1:0] CTM_FILT_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CTM_FILTER_CYCLES = 4;
  localparam int CTM_NUM_FUNCS = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CTM_FN_INTERVAL,
    CTM_FN_PWM_FIXED,
    CTM_FN_PWM_VAR,
    CTM_FN_PULSE_WIDTH_COUNT,
    CTM_FN_CAPTURE
  } ctm_func_t;

  typedef struct packed {
    logic awvalid;
    logic [CTM_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [CTM_ADDR_W-1:0] araddr;
    logic rready;
  } ctm_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctm_axil_resp_t;

  // measuring functions are the only ones that look at the event input
  function automatic logic ctm_is_measure(ctm_func_t fn);
    return (fn == CTM_FN_PULSE_WIDTH_COUNT) || (fn == CTM_FN_CAPTURE);
  endfunction

endpackage

/* rtl/ctm_event_filter.sv */
/*
  Noise filter for one timer event input.
  Assumes the input is already in the clk domain (synchronised upstream).
*/
module ctm_event_filter
  import ctm_pkg::*;
#(
  parameter int FILTER_CYCLES = CTM_FILTER_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level_in,
  input wire logic active,
  input wire logic [1:0] filt_sel,
  output logic level_out
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FILTER_CYCLES - 1);

  logic [CW-1:0] stable_cnt;
  logic need_confirm;

  // a rising level is confirmed when high pulses are filtered, falling likewise
  always_comb
  begin
    need_confirm = 1'b0;
    if (active)
    begin
      need_confirm = level_in ? filt_sel[0] : filt_sel[1];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      level_out <= 1'b0;
      stable_cnt <= '0;
    end
    else if (level_in == level_out)
    begin
      stable_cnt <= '0;
    end
    else if (!need_confirm || stable_cnt == LAST)
    begin
      level_out <= level_in;
      stable_cnt <= '0;
    end
    else
    begin
      stable_cnt <= stable_cnt + CW'(1);
    end
  end

endmodule // ctm_event_filter

/* rtl/ctm_output_track.sv */
/*
  Output status holder for one timer of the pair.
  Assumes the timer output level and run bit come from the same clock.
*/
module ctm_output_track
  import ctm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire ctm_func_t func,
  input wire logic timer_out,
  output logic status
);

  // last level seen under each function, so a return to it restores it
  logic [CTM_NUM_FUNCS-1:0] last_level;
  logic [2:0] idx;

  assign idx = 3'(func);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_level <= '0;
    end
    else if (run)
    begin
      last_level[idx] <= timer_out;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status <= 1'b0;
    end
    else if (run)
    begin
      status <= timer_out;
    end
    else
    begin
      status <= last_level[idx];
    end
  end

endmodule // ctm_output_track

/* rtl/ctm_mode_control.sv */
/*
  Mode control register for a pair of 8-bit timers, with AXI4-Lite slave,
  event input selection and noise filtering.
  Assumes run bits, function codes and timer output levels come from the
  timer logic on clk; the external event pin is asynchronous.
*/
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
// Summary of operation
// R1 - bits 7 and 6 read the upper and lower timer outputs; writes ignored
// R2 - upper status may be meaningless in 16-bit with variable PWM or capture
// R3 - lower status is meaningless while capture is selected
// R4 - stopping a timer keeps its last output level in the status bit
// R5 - after a function change while stopped, show that function's last level or 0
// R6 - input source choice applies only under pulse-width count or capture
// R7 - channel 0: source bit 0 takes the event pin, 1 the internal trigger
// R8 - channel 0: source bit writes are dropped while the lower timer runs
// R9 - other channels: software writes only 0 to the source bit
// R10 - width select 0 gives two 8-bit timers, 1 one 16-bit timer
// R11 - starting variable-cycle PWM with width select 1 clears width select
// R12 - width select writes are dropped while either timer runs
// R13 - upper filter field: 00 none, 01 high, 10 low, 11 both pulses
// R14 - lower filter field uses the same encoding as the upper one
// R15 - filters work only under pulse-width count or capture
// R16 - each filter field write is dropped while its own timer runs
// R17 - unlocked fields still update in a write that hits locked ones
module ctm_mode_control
  import ctm_pkg::*;
#(
  parameter bit CHANNEL_ZERO = 1'b1,
  parameter int FILTER_CYCLES = CTM_FILTER_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire ctm_axil_req_t axil_req,
  output ctm_axil_resp_t axil_resp,
  input wire logic lower_run_bit,
  input wire logic upper_run_bit,
  input wire ctm_func_t lower_func,
  input wire ctm_func_t upper_func,
  input wire logic lower_timer_out,
  input wire logic upper_timer_out,
  input wire logic channel_event_pin,
  input wire logic internal_trigger_signal,
  output logic width_select,
  output logic lower_event_in,
  output logic upper_event_in
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic lower_input_source_select;
  logic [1:0] upper_filter_select;
  logic [1:0] lower_filter_select;
  logic upper_timer_output_status;
  logic lower_timer_output_status;
  logic lower_run_q;
  logic upper_run_q;
  logic start_event;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [CTM_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic write_hit;

  assign do_write = aw_held && w_held && !axil_resp.bvalid;
  assign write_hit = do_write && (aw_addr_q == CTM_MODE_CTRL_OFFSET) && w_strb_q[0];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
      axil_resp.awready <= 1'b1;
    end
    else if (axil_req.awvalid && axil_resp.awready)
    begin
      aw_held <= 1'b1;
      aw_addr_q <= axil_req.awaddr;
      axil_resp.awready <= 1'b0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
    else if (axil_resp.bvalid && axil_req.bready)
    begin
      axil_resp.awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      w_held <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      axil_resp.wready <= 1'b1;
    end
    else if (axil_req.wvalid && axil_resp.wready)
    begin
      w_held <= 1'b1;
      w_data_q <= axil_req.wdata;
      w_strb_q <= axil_req.wstrb;
      axil_resp.wready <= 1'b0;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
    else if (axil_resp.bvalid && axil_req.bready)
    begin
      axil_resp.wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      axil_resp.bvalid <= 1'b0;
      axil_resp.bresp <= CTM_RESP_OKAY;
    end
    else if (do_write)
    begin
      axil_resp.bvalid <= 1'b1;
      axil_resp.bresp <= (aw_addr_q == CTM_MODE_CTRL_OFFSET) ? CTM_RESP_OKAY : CTM_RESP_SLVERR;
    end
    else if (axil_resp.bvalid && axil_req.bready)
    begin
      axil_resp.bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [7:0] mode_readback;

  // status bits come from the trackers; writes never reach them [R1]
  assign mode_readback = {upper_timer_output_status, lower_timer_output_status,
                          lower_input_source_select, width_select,
                          upper_filter_select, lower_filter_select};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      axil_resp.arready <= 1'b1;
      axil_resp.rvalid <= 1'b0;
      axil_resp.rdata <= '0;
      axil_resp.rresp <= CTM_RESP_OKAY;
    end
    else if (axil_req.arvalid && axil_resp.arready)
    begin
      axil_resp.arready <= 1'b0;
      axil_resp.rvalid <= 1'b1;
      if (axil_req.araddr == CTM_MODE_CTRL_OFFSET)
      begin
        axil_resp.rdata <= {24'h000000, mode_readback};
        axil_resp.rresp <= CTM_RESP_OKAY;
      end
      else
      begin
        axil_resp.rdata <= '0;
        axil_resp.rresp <= CTM_RESP_SLVERR;
      end
    end
    else if (axil_resp.rvalid && axil_req.rready)
    begin
      axil_resp.rvalid <= 1'b0;
      axil_resp.arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // writable fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lower_run_q <= 1'b0;
      upper_run_q <= 1'b0;
    end
    else
    begin
      lower_run_q <= lower_run_bit;
      upper_run_q <= upper_run_bit;
    end
  end

  // variable PWM is started through either timer's run bit
  assign start_event = (lower_run_bit && !lower_run_q && lower_func == CTM_FN_PWM_VAR)
                    || (upper_run_bit && !upper_run_q && upper_func == CTM_FN_PWM_VAR);

  // each field has its own lock, so one write may update some and not others [R17]
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lower_input_source_select <= CTM_MODE_CTRL_RESET[CTM_INPUT_SRC_BIT];
    end
    else if (write_hit && !lower_run_bit)
    begin
      lower_input_source_select <= w_data_q[CTM_INPUT_SRC_BIT]; // [R8]
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      width_select <= CTM_MODE_CTRL_RESET[CTM_WIDTH_SEL_BIT];
    end
    else if (start_event)
    begin
      width_select <= 1'b0; // [R11]
    end
    else if (write_hit && !lower_run_bit && !upper_run_bit)
    begin
      width_select <= w_data_q[CTM_WIDTH_SEL_BIT]; // [R12] [R10]
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      upper_filter_select <= CTM_MODE_CTRL_RESET[CTM_UPPER_FILT_LSB +: 2];
    end
    else if (write_hit && !upper_run_bit)
    begin
      upper_filter_select <= w_data_q[CTM_UPPER_FILT_LSB +: 2]; // [R16]
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lower_filter_select <= CTM_MODE_CTRL_RESET[CTM_LOWER_FILT_LSB +: 2];
    end
    else if (write_hit && !lower_run_bit)
    begin
      lower_filter_select <= w_data_q[CTM_LOWER_FILT_LSB +: 2]; // [R16]
    end
  end

  // ----------------------------------------------------------------
  // output status tracking
  // ----------------------------------------------------------------
  // capture and 16-bit variable PWM levels pass through raw; their value
  // is not meaningful there and software should not rely on it [R2] [R3]
  ctm_output_track u_upper_track (
    .clk(clk),
    .rst(rst),
    .run(upper_run_bit),
    .func(upper_func),
    .timer_out(upper_timer_out),
    .status(upper_timer_output_status) // [R4] [R5]
  );

  ctm_output_track u_lower_track (
    .clk(clk),
    .rst(rst),
    .run(lower_run_bit),
    .func(lower_func),
    .timer_out(lower_timer_out),
    .status(lower_timer_output_status) // [R4] [R5]
  );

  // ----------------------------------------------------------------
  // event input selection and filtering
  // ----------------------------------------------------------------
  logic [2:0] pin_sync;
  logic pin_level;
  logic lower_src;
  logic [1:0] filt_in;
  logic [1:0] filt_active;
  logic [1:0] filt_out;
  logic [1:0] filt_sel [2];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_sync <= '0;
      pin_level <= 1'b0;
    end
    else
    begin
      pin_sync <= {pin_sync[1:0], channel_event_pin};
      if (pin_sync[1] == pin_sync[2])
      begin
        pin_level <= pin_sync[2];
      end
    end
  end

  // non-zero channels never look at the source bit, so a stray 1 is harmless [R9]
  always_comb
  begin
    lower_src = pin_level;
    if (CHANNEL_ZERO && ctm_is_measure(lower_func) && lower_input_source_select) // [R6]
    begin
      lower_src = internal_trigger_signal; // [R7]
    end
  end

  assign filt_in = {pin_level, lower_src};
  assign filt_active = {ctm_is_measure(upper_func), ctm_is_measure(lower_func)}; // [R15]
  assign filt_sel[0] = lower_filter_select; // [R14]
  assign filt_sel[1] = upper_filter_select; // [R13]

  for (genvar i = 0; i < 2; i++)
  begin : g_filter
    ctm_event_filter #(
      .FILTER_CYCLES(FILTER_CYCLES)
    ) u_filter (
      .clk(clk),
      .rst(rst),
      .level_in(filt_in[i]),
      .active(filt_active[i]),
      .filt_sel(filt_sel[i]),
      .level_out(filt_out[i])
    );
  end

  assign lower_event_in = filt_out[0];
  assign upper_event_in = filt_out[1];

endmodule // ctm_mode_control

/* bench/ctm_mode_control_chk.sv */
/*
  Concurrent checks for the timer-pair mode control block.
  Assumes it is bound to ctm_mode_control and sees only its ports.
*/
module ctm_mode_control_chk
  import ctm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ctm_axil_req_t axil_req,
  input wire ctm_axil_resp_t axil_resp,
  input wire logic lower_run_bit,
  input wire logic upper_run_bit,
  input wire ctm_func_t lower_func,
  input wire ctm_func_t upper_func,
  input wire logic width_select
);
  // ----------------------------------------------------------------
  // bus and lock properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_read_answer: assert property (axil_req.arvalid && axil_resp.arready |=> axil_resp.rvalid)
    else $error("read answer missing");
  a_write_answer: assert property (axil_req.awvalid && axil_resp.awready && axil_req.wvalid
    && axil_resp.wready |-> ##[1:3] axil_resp.bvalid)
    else $error("write answer missing");
  a_read_single: assert property (axil_resp.rvalid |-> !axil_resp.arready)
    else $error("second read taken");
  a_write_single: assert property (axil_resp.bvalid |-> !axil_resp.awready && !axil_resp.wready)
    else $error("second write taken");
  a_read_upper: assert property (axil_resp.rvalid |-> axil_resp.rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_err: assert property (axil_req.arvalid && axil_resp.arready
    && axil_req.araddr != CTM_MODE_CTRL_OFFSET
    |=> axil_resp.rresp == CTM_RESP_SLVERR && axil_resp.rdata == 32'h0)
    else $error("unmapped read answered");
  a_width_lock: assert property ((lower_run_bit || upper_run_bit) [*3]
    |-> $stable(width_select)
    || $past(lower_func == CTM_FN_PWM_VAR || upper_func == CTM_FN_PWM_VAR))
    else $error("width select written while running");
  a_width_clear: assert property (width_select
    && (($rose(upper_run_bit) && upper_func == CTM_FN_PWM_VAR)
    || ($rose(lower_run_bit) && lower_func == CTM_FN_PWM_VAR))
    |-> ##[1:2] !width_select)
    else $error("width select not cleared");
endmodule // ctm_mode_control_chk

bind ctm_mode_control ctm_mode_control_chk chk (
  .clk(clk),
  .rst(rst),
  .axil_req(axil_req),
  .axil_resp(axil_resp),
  .lower_run_bit(lower_run_bit),
  .upper_run_bit(upper_run_bit),
  .lower_func(lower_func),
  .upper_func(upper_func),
  .width_select(width_select)
);

/* bench/composite_timer_mode_control_bench.sv */
/*
  Self-checking bench for the timer-pair mode control block.
  Assumes ctm_pkg and ctm_mode_control; register at byte address 0x000.
*/
module composite_timer_mode_control_bench
  import ctm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk;
  logic rst;
  ctm_axil_req_t req;
  ctm_axil_resp_t rsp;
  logic lrun, urun, lout, uout, pin, trig;
  ctm_func_t lfn, ufn;
  logic wsel, lev, uev;
  int bad_count, total_checks, seed;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];

  // four-edge filter outlasts a two-cycle glitch; channel zero may set the source bit
  ctm_mode_control #(.FILTER_CYCLES(4)) uut (
    .clk(clk),
    .rst(rst),
    .axil_req(req),
    .axil_resp(rsp),
    .lower_run_bit(lrun),
    .upper_run_bit(urun),
    .lower_func(lfn),
    .upper_func(ufn),
    .lower_timer_out(lout),
    .upper_timer_out(uout),
    .channel_event_pin(pin),
    .internal_trigger_signal(trig),
    .width_select(wsel),
    .lower_event_in(lev),
    .upper_event_in(uev)
  );

  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ready lines stay high, so each answer is taken on its first cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] eb);
    exp_b.push_back(eb);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'h0;
      if (rsp.bvalid)
        return;
    end
    bad_count++;
    summarize();
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [7:0] d);
    exp_r.push_back({r, 24'h0, d});
    req.arvalid <= 1'h1;
    req.araddr <= a;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'h0;
      if (rsp.rvalid)
        return;
    end
    bad_count++;
    summarize();
  endtask

  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst && rsp.rvalid && req.rready)
      chk("read", exp_r.pop_front(), {rsp.rresp, rsp.rdata});
    if (!rst && rsp.bvalid && req.bready)
      chk("bresp", {32'h0, exp_b.pop_front()}, {32'h0, rsp.bresp});
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    seed = 73155;
    bad_count = 0;
    total_checks = 0;
    rst = 1'h1;
    req = '0;
    req.bready = 1'h1;
    req.rready = 1'h1;
    {lrun, urun, lout, uout, pin, trig} = 6'h0;
    lfn = CTM_FN_INTERVAL;
    ufn = CTM_FN_INTERVAL;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(12'h000, CTM_RESP_OKAY, CTM_MODE_CTRL_RESET);
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($random(seed));
      wr(12'h000, d, CTM_RESP_OKAY);
      rd(12'h000, CTM_RESP_OKAY, {2'h0, d[5:0]});
      chk("width_select", {33'h0, d[4]}, {33'h0, wsel});
    end
    wr(12'h004, 8'hff, CTM_RESP_SLVERR);
    rd(12'h004, CTM_RESP_SLVERR, 8'h00);
    rd(12'h000, CTM_RESP_OKAY, {2'h0, d[5:0]});
    $display("test fields done");
    wr(12'h000, 8'h3f, CTM_RESP_OKAY);
    lrun <= 1'h1;
    cyc(2);
    wr(12'h000, 8'h00, CTM_RESP_OKAY);
    rd(12'h000, CTM_RESP_OKAY, 8'h33);
    lrun <= 1'h0;
    urun <= 1'h1;
    cyc(2);
    wr(12'h000, 8'h0c, CTM_RESP_OKAY);
    rd(12'h000, CTM_RESP_OKAY, 8'h10);
    $display("test locks done");
    uout <= 1'h1;
    cyc(3);
    rd(12'h000, CTM_RESP_OKAY, 8'h90);
    urun <= 1'h0;
    uout <= 1'h0;
    cyc(3);
    rd(12'h000, CTM_RESP_OKAY, 8'h90);
    ufn <= CTM_FN_PULSE_WIDTH_COUNT;
    cyc(3);
    rd(12'h000, CTM_RESP_OKAY, 8'h10);
    ufn <= CTM_FN_INTERVAL;
    cyc(3);
    rd(12'h000, CTM_RESP_OKAY, 8'h90);
    $display("test status done");
    ufn <= CTM_FN_PWM_VAR;
    cyc(1);
    urun <= 1'h1;
    cyc(4);
    chk("width_select", 34'h0, {33'h0, wsel});
    rd(12'h000, CTM_RESP_OKAY, 8'h00);
    urun <= 1'h0;
    ufn <= CTM_FN_INTERVAL;
    cyc(2);
    $display("test width clear done");
    lfn <= CTM_FN_PULSE_WIDTH_COUNT;
    wr(12'h000, 8'h2c, CTM_RESP_OKAY);
    trig <= 1'h1;
    cyc(8);
    chk("lower_event_in", 34'h1, {33'h0, lev});
    lfn <= CTM_FN_INTERVAL;
    cyc(8);
    chk("lower_event_in", 34'h0, {33'h0, lev});
    pin <= 1'h1;
    // five edges through sync and an idle filter; an active one needs three more
    cyc(6);
    chk("lower_event_in", 34'h1, {33'h0, lev});
    chk("upper_event_in", 34'h1, {33'h0, uev});
    ufn <= CTM_FN_CAPTURE;
    pin <= 1'h0;
    cyc(2);
    pin <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      cyc(1);
      chk("upper_event_in", 34'h1, {33'h0, uev});
    end
    pin <= 1'h0;
    cyc(10);
    chk("upper_event_in", 34'h0, {33'h0, uev});
    $display("test events done");
    summarize();
  end
endmodule // composite_timer_mode_control_bench
